// >>> hw/cidrc_pkg.sv
// constants and types for the caller id receiver control block
// assumes a 10 MHz reference clock and 1-bit sliced amplifier outputs
package cidrc_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned BAUD = 1200;
	// one fsk bit, rounded down
	localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
	// tone guard times in microseconds
	localparam int unsigned GP_US = 40;
	localparam int unsigned GA_US = 10;
	localparam int unsigned GP_CYC = (GP_US * CLK_HZ + 999999) / 1000000;
	localparam int unsigned GA_CYC = (GA_US * CLK_HZ + 999999) / 1000000;
	localparam int unsigned CW = 16;
	localparam int unsigned NDATA = 8;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] A_STATUS = 4'h0;
	localparam logic [3:0] A_MASK = 4'h4;
	localparam logic [3:0] A_DATA = 4'h8;
	localparam logic [3:0] A_STATE = 4'hc;
	localparam int unsigned NEV = 4;
	localparam int unsigned EV_BYTE = 0;
	localparam int unsigned EV_TONE = 1;
	localparam int unsigned EV_FRAME = 2;
	localparam int unsigned EV_CARR = 3;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		F_FSK = 3'b000,
		F_CAS_HS = 3'b001,
		F_CAS_LN = 3'b010,
		F_PD = 3'b011,
		F_RSV = 3'b100
	} cidrc_func_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} cidrc_rx_t;

	// power enables, high keeps the section running
	typedef struct packed {
		logic osc;
		logic line_amp;
		logic handset_amp;
		logic demod;
		logic tone;
	} cidrc_pwr_t;

	typedef struct packed {
		logic stop;
		logic [7:0] data;
	} cidrc_byte_t;

	localparam cidrc_pwr_t PWR_OFF = 5'h00;
	localparam cidrc_byte_t BYTE_IDLE = 9'h1ff;

endpackage

// >>> hw/cidrc_top.sv
// control, fsk framing and tone guard logic of the caller id receiver
// assumes all inputs synchronous to ref_clk; analog cores sit outside
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps

// Notes on behaviour
// - fsk data as bit stream or byte buffer
// - buffer also keeps stop bit, shifted last
// - stream mode gives bit and byte strobes
// - carrier status out; no carrier mutes stream data
// - power down stops amps, demod, tone, oscillator
// - fsk selected keeps tone detector off
// - tone selected keeps fsk demodulator off
// - demodulator fed only from line amp
// - tone detector input follows selected amp
// - line amp selected ignores handset amp
// - handset amp selected ignores line amp
// - tone modes switch shared pin to tone
// - tone output low on tone, high after
// - function code picks mode; zero code reserved
module cidrc_top #(
	parameter int unsigned BIT_CYC = cidrc_pkg::BIT_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// control pins
	input wire logic iface_format_sel,
	input wire logic function_sel_a,
	input wire logic function_sel_b,
	// front end and cores
	input wire logic line_amp_out,
	input wire logic handset_amp_out,
	input wire logic fsk_demod_bit,
	input wire logic fsk_carrier,
	input wire logic tone_pair_present,
	// host serial read clock
	input wire logic host_shift_clk,
	// routing and power
	output logic fsk_path_in,
	output logic tone_path_in,
	output cidrc_pkg::cidrc_pwr_t pwr_en,
	// data side
	output logic data_out,
	output logic bit_strobe,
	output logic byte_strobe,
	output logic carrier_det,
	output logic shared_ready_or_tone_out,
	output logic irq
);

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	localparam logic [15:0] BIT_LD = 16'(BIT_CYC - 1);
	localparam logic [15:0] HALF_LD = 16'(BIT_CYC / 2 - 1);
	localparam logic [15:0] GP_LD = 16'(cidrc_pkg::GP_CYC - 1);
	localparam logic [15:0] GA_LD = 16'(cidrc_pkg::GA_CYC - 1);
	localparam logic [3:0] LAST_BIT = 4'(cidrc_pkg::NDATA - 1);

	cidrc_pkg::cidrc_func_t func;
	wire logic fsk_sel;
	wire logic cas_sel;
	wire logic pd_sel;
	wire logic buf_mode;
	cidrc_pkg::cidrc_pwr_t next_pwr;

	// reserved code is run as full power down
	assign func = (function_sel_a && function_sel_b) ? cidrc_pkg::F_FSK :
		function_sel_a ? cidrc_pkg::F_CAS_HS :
		function_sel_b ? cidrc_pkg::F_CAS_LN :
		iface_format_sel ? cidrc_pkg::F_PD : cidrc_pkg::F_RSV;
	assign fsk_sel = func == cidrc_pkg::F_FSK;
	assign cas_sel = func == cidrc_pkg::F_CAS_HS || func == cidrc_pkg::F_CAS_LN;
	assign pd_sel = func == cidrc_pkg::F_PD || func == cidrc_pkg::F_RSV;
	assign buf_mode = iface_format_sel;

	always_comb begin
		next_pwr = cidrc_pkg::PWR_OFF;
		if (!pd_sel) begin
			next_pwr.osc = 1'b1;
			next_pwr.line_amp = 1'b1;
			next_pwr.handset_amp = 1'b1;
			next_pwr.demod = fsk_sel;
			next_pwr.tone = cas_sel;
		end
	end

	// ----------------------------------------
	// input routing
	// ----------------------------------------
	wire logic next_fsk_in;
	wire logic next_tone_in;

	assign next_fsk_in = fsk_sel & line_amp_out;
	assign next_tone_in = (func == cidrc_pkg::F_CAS_HS) ? handset_amp_out :
		(func == cidrc_pkg::F_CAS_LN) ? line_amp_out : 1'b0;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pwr_en <= cidrc_pkg::PWR_OFF;
			fsk_path_in <= 1'b0;
			tone_path_in <= 1'b0;
		end else begin
			pwr_en <= next_pwr;
			fsk_path_in <= next_fsk_in;
			tone_path_in <= next_tone_in;
		end
	end

	// ----------------------------------------
	// fsk framing
	// ----------------------------------------
	cidrc_pkg::cidrc_rx_t rx_st;
	cidrc_pkg::cidrc_rx_t next_rx_st;
	logic [15:0] rx_cnt;
	logic [3:0] rx_idx;
	logic [7:0] rx_sh;
	logic demod_q;
	wire logic rx_run;
	wire logic tick;
	wire logic samp;
	wire logic done;
	wire logic start_edge;

	// a carrier drop aborts the byte in flight
	assign rx_run = fsk_sel && fsk_carrier;
	assign tick = rx_cnt == 16'h0000;
	assign start_edge = demod_q && !fsk_demod_bit;
	// strobes and byte capture die with the carrier, even in the cycle it drops
	assign samp = rx_run && rx_st == cidrc_pkg::RX_DATA && tick;
	assign done = rx_run && rx_st == cidrc_pkg::RX_STOP && tick;

	always_comb begin
		next_rx_st = rx_st;
		case (rx_st)
			cidrc_pkg::RX_IDLE: begin
				if (start_edge)
					next_rx_st = cidrc_pkg::RX_START;
			end
			cidrc_pkg::RX_START: begin
				if (tick)
					next_rx_st = fsk_demod_bit ? cidrc_pkg::RX_IDLE : cidrc_pkg::RX_DATA;
			end
			cidrc_pkg::RX_DATA: begin
				if (tick && rx_idx == LAST_BIT)
					next_rx_st = cidrc_pkg::RX_STOP;
			end
			default: begin
				if (tick)
					next_rx_st = cidrc_pkg::RX_IDLE;
			end
		endcase
		if (!rx_run)
			next_rx_st = cidrc_pkg::RX_IDLE;
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rx_st <= cidrc_pkg::RX_IDLE;
			rx_cnt <= 16'h0000;
			rx_idx <= 4'h0;
			rx_sh <= 8'h00;
			demod_q <= 1'b1;
		end else begin
			rx_st <= next_rx_st;
			demod_q <= fsk_demod_bit;
			if (rx_st == cidrc_pkg::RX_IDLE)
				rx_cnt <= HALF_LD;
			else if (tick)
				rx_cnt <= BIT_LD;
			else
				rx_cnt <= rx_cnt - 16'h0001;
			if (rx_st != cidrc_pkg::RX_DATA)
				rx_idx <= 4'h0;
			else if (tick)
				rx_idx <= rx_idx + 4'h1;
			if (samp)
				rx_sh <= {fsk_demod_bit, rx_sh[7:1]};
		end
	end

	// ----------------------------------------
	// byte buffer and host readout
	// ----------------------------------------
	cidrc_pkg::cidrc_byte_t hold;
	cidrc_pkg::cidrc_byte_t last_byte;
	logic ready;
	logic shift_q;
	wire logic shift_edge;
	wire logic next_data;

	assign shift_edge = host_shift_clk && !shift_q;
	// stream data idles at mark while muted
	assign next_data = buf_mode ? hold[0] : (rx_run ? fsk_demod_bit : 1'b1);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			hold <= cidrc_pkg::BYTE_IDLE;
			last_byte <= cidrc_pkg::BYTE_IDLE;
			ready <= 1'b0;
			shift_q <= 1'b0;
		end else begin
			shift_q <= host_shift_clk;
			if (done) begin
				hold <= {fsk_demod_bit, rx_sh};
				last_byte <= {fsk_demod_bit, rx_sh};
			end else if (shift_edge && buf_mode) begin
				hold <= {1'b1, hold[8:1]};
			end
			// a new byte wins over a shift in the same cycle
			if (done && buf_mode)
				ready <= 1'b1;
			else if (shift_edge || !buf_mode)
				ready <= 1'b0;
		end
	end

	// ----------------------------------------
	// tone guard timing
	// ----------------------------------------
	logic tone_n;
	logic [15:0] g_cnt;
	wire logic g_hit;

	assign g_hit = tone_n ? (g_cnt == GP_LD) : (g_cnt == GA_LD);

	// present and absent times both need an unbroken run
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tone_n <= 1'b1;
			g_cnt <= 16'h0000;
		end else if (!cas_sel) begin
			tone_n <= 1'b1;
			g_cnt <= 16'h0000;
		end else if (tone_pair_present == tone_n) begin
			if (g_hit) begin
				tone_n <= !tone_n;
				g_cnt <= 16'h0000;
			end else begin
				g_cnt <= g_cnt + 16'h0001;
			end
		end else begin
			g_cnt <= 16'h0000;
		end
	end

	// ----------------------------------------
	// output pins
	// ----------------------------------------
	wire logic next_shared;

	assign next_shared = cas_sel ? tone_n : !(fsk_sel && ready);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			data_out <= 1'b1;
			bit_strobe <= 1'b0;
			byte_strobe <= 1'b0;
			carrier_det <= 1'b0;
			shared_ready_or_tone_out <= 1'b1;
		end else begin
			data_out <= next_data;
			bit_strobe <= samp && !buf_mode;
			byte_strobe <= done && !buf_mode;
			carrier_det <= rx_run;
			shared_ready_or_tone_out <= next_shared;
		end
	end

	// ----------------------------------------
	// status, mask and register port
	// ----------------------------------------
	logic [3:0] sts;
	logic [3:0] mask;
	logic tone_nq;
	wire logic [3:0] ev;
	wire logic [3:0] w1c;
	wire logic [3:0] next_sts;
	wire logic [31:0] next_rdata;

	assign ev[cidrc_pkg::EV_BYTE] = done;
	assign ev[cidrc_pkg::EV_TONE] = tone_nq && !tone_n;
	assign ev[cidrc_pkg::EV_FRAME] = done && !fsk_demod_bit;
	assign ev[cidrc_pkg::EV_CARR] = carrier_det && !rx_run;
	assign w1c = (reg_wr && reg_addr == cidrc_pkg::A_STATUS) ? reg_wdata[3:0] : 4'h0;
	// set beats clear in the same cycle
	assign next_sts = (sts & ~w1c) | ev;
	assign next_rdata = (reg_addr == cidrc_pkg::A_STATUS) ? {28'h0, sts} :
		(reg_addr == cidrc_pkg::A_MASK) ? {28'h0, mask} :
		(reg_addr == cidrc_pkg::A_DATA) ? {23'h0, last_byte} :
		(reg_addr == cidrc_pkg::A_STATE) ? {25'h0, func, tone_n, ready, buf_mode, rx_run} :
		32'h0;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			sts <= 4'h0;
			mask <= 4'h0;
			tone_nq <= 1'b1;
			irq <= 1'b0;
			reg_rdata <= 32'h0;
		end else begin
			sts <= next_sts;
			tone_nq <= tone_n;
			irq <= |(next_sts & mask);
			if (reg_wr && reg_addr == cidrc_pkg::A_MASK)
				mask <= reg_wdata[3:0];
			reg_rdata <= reg_rd ? next_rdata : 32'h0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	chk_pd_all_off: assert property (pd_sel ##1 pd_sel |=> pwr_en == cidrc_pkg::PWR_OFF)
		else $error("power down left a section on");
	chk_fsk_tone_off: assert property (fsk_sel |=> !pwr_en.tone && pwr_en.demod)
		else $error("tone detector on in fsk mode");
	chk_cas_demod_off: assert property (cas_sel |=> !pwr_en.demod && pwr_en.tone)
		else $error("demodulator on in tone mode");
	chk_fsk_from_line: assert property (##1 fsk_path_in |-> $past(line_amp_out) && $past(fsk_sel))
		else $error("demodulator fed from wrong source");
	chk_hs_route: assert property (func == cidrc_pkg::F_CAS_HS |=> tone_path_in == $past(handset_amp_out))
		else $error("handset tone route wrong");
	chk_ln_route: assert property (func == cidrc_pkg::F_CAS_LN |=> tone_path_in == $past(line_amp_out))
		else $error("line tone route wrong");
	chk_shared_tone: assert property (cas_sel |=> shared_ready_or_tone_out == $past(tone_n))
		else $error("shared pin not tone in tone mode");
	chk_tone_accept: assert property ($fell(tone_n) |-> $past(g_cnt) == GP_LD && $past(tone_pair_present))
		else $error("tone accepted without full guard");
	chk_mute_data: assert property (!buf_mode && !rx_run |=> data_out && !bit_strobe && !byte_strobe)
		else $error("data not muted without carrier");
	chk_strobe_space: assert property (bit_strobe |=> !bit_strobe [*2])
		else $error("bit strobes too close");
	chk_stop_kept: assert property (done |=> hold.stop == $past(fsk_demod_bit))
		else $error("stop bit not held");
	chk_irq_level: assert property (##1 irq == |($past(next_sts) & $past(mask)))
		else $error("interrupt level wrong");

	cov_byte_buf: cover property (done && buf_mode ##1 ready);
	cov_byte_str: cover property (byte_strobe);
	cov_tone_det: cover property ($fell(tone_n) ##[1:1000] $rose(tone_n));
	cov_frame_err: cover property (ev[cidrc_pkg::EV_FRAME]);

endmodule

// >>> tb/cidrc_host_model.sv
// host controller model: drives the control pins and shifts the byte buffer out
// assumes ref_clk comes from the bench and data_out is registered in the device
`timescale 1ns/10ps
module cidrc_host_model (
	// clock
	input wire logic ref_clk,
	// from device
	input wire logic data_out,
	// to device
	output logic iface_format_sel,
	output logic function_sel_a,
	output logic function_sel_b,
	output logic host_shift_clk
);
	initial begin
		iface_format_sel = 1'h0;
		function_sel_a = 1'h1;
		function_sel_b = 1'h1;
		host_shift_clk = 1'h0;
	end

	// ----------------------------------------
	// mode control
	// ----------------------------------------
	// code 0 fsk, 1 handset tone, 2 line tone, 3 power down
	// power down forces format high so the all-zero code never appears
	task automatic set_mode(input logic fmt, input logic [1:0] code);
		@(posedge ref_clk);
		iface_format_sel <= fmt | (code == 2'h3);
		function_sel_a <= (code == 2'h0) || (code == 2'h1);
		function_sel_b <= (code == 2'h0) || (code == 2'h2);
		repeat (3) @(posedge ref_clk);
	endtask

	// ----------------------------------------
	// buffer readout
	// ----------------------------------------
	// bit0 shows first; a shift needs two cycles to reach data_out, so wait four
	task automatic read_buffer(output logic [8:0] v);
		int i;
		for (i = 0; i < 9; i++) begin
			v[i] = data_out;
			@(posedge ref_clk);
			host_shift_clk <= 1'h1;
			@(posedge ref_clk);
			host_shift_clk <= 1'h0;
			repeat (3) @(posedge ref_clk);
		end
	endtask
endmodule

// >>> tb/cidrc_top_tb.sv
// self-checking bench for the caller id receiver control block
// assumes a 10 MHz clock and a shortened fsk bit time
`timescale 1ns/10ps
module cidrc_top_tb;
	localparam int unsigned BC = 16;
	logic ref_clk, nrst, reg_wr, reg_rd, line_amp_out, handset_amp_out;
	logic fsk_demod_bit, fsk_carrier, tone_pair_present;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic iface_format_sel, function_sel_a, function_sel_b, host_shift_clk;
	logic fsk_path_in, tone_path_in, data_out, bit_strobe, byte_strobe, carrier_det;
	logic shared_ready_or_tone_out, irq;
	cidrc_pkg::cidrc_pwr_t pwr_en;
	int num_errors = 0;
	int n_compared = 0;
	int nbit = 0;
	int nbyte = 0;

	cidrc_top #(.BIT_CYC(BC)) u_cidrc_top (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.iface_format_sel(iface_format_sel), .function_sel_a(function_sel_a),
		.function_sel_b(function_sel_b), .line_amp_out(line_amp_out), .handset_amp_out(handset_amp_out),
		.fsk_demod_bit(fsk_demod_bit), .fsk_carrier(fsk_carrier), .tone_pair_present(tone_pair_present),
		.host_shift_clk(host_shift_clk), .fsk_path_in(fsk_path_in), .tone_path_in(tone_path_in),
		.pwr_en(pwr_en), .data_out(data_out), .bit_strobe(bit_strobe), .byte_strobe(byte_strobe),
		.carrier_det(carrier_det), .shared_ready_or_tone_out(shared_ready_or_tone_out), .irq(irq));
	cidrc_host_model u_cidrc_host_model (.ref_clk(ref_clk), .data_out(data_out),
		.iface_format_sel(iface_format_sel), .function_sel_a(function_sel_a),
		.function_sel_b(function_sel_b), .host_shift_clk(host_shift_clk));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (bit_strobe === 1'h1) nbit++;
		if (byte_strobe === 1'h1) nbyte++;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic reg_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		@(posedge ref_clk);
		check(what, reg_rdata, exp);
	endtask
	task automatic route(input logic ln, input logic hs, input logic ef, input logic et);
		@(posedge ref_clk);
		line_amp_out <= ln;
		handset_amp_out <= hs;
		repeat (3) @(posedge ref_clk);
		check("fsk path", fsk_path_in, ef);
		check("tone path", tone_path_in, et);
	endtask
	// start bit, eight data bits lsb first, stop bit; stream data checked mid-bit
	task automatic send_frame(input logic [7:0] d, input logic stop, input logic strm);
		logic [9:0] f;
		int i;
		f = {stop, d, 1'h0};
		for (i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			fsk_demod_bit <= f[i];
			repeat (BC / 2) @(posedge ref_clk);
			if (strm) check("stream data", data_out, f[i]);
			repeat (BC / 2 - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		fsk_demod_bit <= 1'h1;
		repeat (BC) @(posedge ref_clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_power_route();
		u_cidrc_host_model.set_mode(1'h0, 2'h0);
		check("pwr fsk", pwr_en, 32'h1e);
		route(1'h1, 1'h0, 1'h1, 1'h0);
		route(1'h0, 1'h1, 1'h0, 1'h0);
		u_cidrc_host_model.set_mode(1'h0, 2'h1);
		check("pwr handset tone", pwr_en, 32'h1d);
		route(1'h1, 1'h0, 1'h0, 1'h0);
		route(1'h0, 1'h1, 1'h0, 1'h1);
		u_cidrc_host_model.set_mode(1'h0, 2'h2);
		check("pwr line tone", pwr_en, 32'h1d);
		route(1'h0, 1'h1, 1'h0, 1'h0);
		route(1'h1, 1'h0, 1'h0, 1'h1);
		u_cidrc_host_model.set_mode(1'h1, 2'h3);
		check("pwr down", pwr_en, 32'h00);
	endtask
	task automatic t_stream();
		u_cidrc_host_model.set_mode(1'h0, 2'h0);
		fsk_carrier <= 1'h1;
		repeat (4) @(posedge ref_clk);
		check("carrier", carrier_det, 32'h1);
		nbit = 0;
		nbyte = 0;
		send_frame(8'ha5, 1'h1, 1'h1);
		check("bit strobes", nbit, 32'h8);
		check("byte strobes", nbyte, 32'h1);
		reg_chk("held byte", cidrc_pkg::A_DATA, 32'h1a5);
		fsk_demod_bit <= 1'h0;
		fsk_carrier <= 1'h0;
		repeat (4) @(posedge ref_clk);
		check("carrier gone", carrier_det, 32'h0);
		check("muted data", data_out, 32'h1);
		fsk_demod_bit <= 1'h1;
		fsk_carrier <= 1'h1;
	endtask
	task automatic t_buffer();
		logic [8:0] v;
		u_cidrc_host_model.set_mode(1'h1, 2'h0);
		reg_write(cidrc_pkg::A_STATUS, 32'hf);
		nbit = 0;
		nbyte = 0;
		send_frame(8'h3c, 1'h0, 1'h0);
		check("ready low", shared_ready_or_tone_out, 32'h0);
		u_cidrc_host_model.read_buffer(v);
		check("shifted byte", v, 32'h03c);
		check("ready cleared", shared_ready_or_tone_out, 32'h1);
		check("no strobes", nbit, 32'h0);
		check("no byte strobes", nbyte, 32'h0);
		reg_chk("framing status", cidrc_pkg::A_STATUS, 32'h5);
	endtask
	task automatic t_tone();
		u_cidrc_host_model.set_mode(1'h0, 2'h2);
		reg_write(cidrc_pkg::A_STATUS, 32'hf);
		reg_write(cidrc_pkg::A_MASK, 32'h0);
		check("tone idle", shared_ready_or_tone_out, 32'h1);
		tone_pair_present <= 1'h1;
		repeat (cidrc_pkg::GP_CYC - 10) @(posedge ref_clk);
		check("tone early", shared_ready_or_tone_out, 32'h1);
		repeat (20) @(posedge ref_clk);
		check("tone seen", shared_ready_or_tone_out, 32'h0);
		reg_chk("tone status", cidrc_pkg::A_STATUS, 32'h2);
		check("irq masked", irq, 32'h0);
		reg_write(cidrc_pkg::A_MASK, 32'h2);
		tone_pair_present <= 1'h0;
		repeat (2) @(posedge ref_clk);
		check("irq raised", irq, 32'h1);
		repeat (cidrc_pkg::GA_CYC - 12) @(posedge ref_clk);
		check("tone bridged", shared_ready_or_tone_out, 32'h0);
		repeat (20) @(posedge ref_clk);
		check("tone ended", shared_ready_or_tone_out, 32'h1);
		reg_write(cidrc_pkg::A_STATUS, 32'h2);
		repeat (2) @(posedge ref_clk);
		check("irq cleared", irq, 32'h0);
		reg_chk("unmapped", 4'h2, 32'h0);
		reg_chk("state word", cidrc_pkg::A_STATE, 32'h28);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		#500000;
		num_errors++;
		end_of_test();
	end
	initial begin
		nrst = 1'h0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		line_amp_out = 1'h0;
		handset_amp_out = 1'h0;
		fsk_demod_bit = 1'h1;
		fsk_carrier = 1'h0;
		tone_pair_present = 1'h0;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'h1;
		@(posedge ref_clk);
		t_power_route();
		t_stream();
		t_buffer();
		t_tone();
		end_of_test();
	end
endmodule
